/* File: design/evpd_params.svh */
// constants for the exception vector priority decoder
`ifndef EVPD_PARAMS_SVH
`define EVPD_PARAMS_SVH
// -----------------------------------------------------------------
// vector addresses
// -----------------------------------------------------------------
`define EVPD_VEC_SYSRST 16'hFFFE
`define EVPD_VEC_CLKMON 16'hFFFC
`define EVPD_VEC_WDOG   16'hFFFA
`define EVPD_VEC_TRAP   16'hFFF8
`define EVPD_VEC_SWI    16'hFFF6
`define EVPD_VEC_NONMASKABLE_REQUEST_LINE   16'hFFF4
`define EVPD_VEC_IRQ    16'hFFF2
`define EVPD_VEC_PAGE   8'hFF
// -----------------------------------------------------------------
// source layout
// -----------------------------------------------------------------
`define EVPD_NUM_PERIPH 121
`define EVPD_NUM_MASK   122
`define EVPD_NUM_INJ    123
`define EVPD_IRQ_IDX    121
`define EVPD_NONMASKABLE_REQUEST_LINE_IDX   122
`define EVPD_IDX_W      7
`define EVPD_RST_SYS    0
`define EVPD_RST_CLKMON 1
`define EVPD_RST_WDOG   2
// -----------------------------------------------------------------
// promotion select
// -----------------------------------------------------------------
`define EVPD_PSEL_LIMIT 8'hF2
`define EVPD_PSEL_RST   8'hF2
`endif

/* File: design/evpd_pkg.sv */
// types for the exception vector priority decoder
package evpd_pkg;
`include "evpd_params.svh"
  typedef struct packed {
    logic [1:0]                  nonmaskable_request_line_sync;
    logic [1:0]                  irq_sync;
    logic [7:0]                  psel;
    logic                        inj_en;
    logic [`EVPD_NUM_INJ-1:0]    inj;
    logic [15:0]                 last_vec;
    logic [15:0]                 vec;
    logic                        vec_valid;
  } evpd_state_t;
endpackage

/* File: design/evpd_req_if.sv */
// maskable request bundle between decoder top and encoder
`timescale 1ns/1ps
`include "evpd_params.svh"
interface evpd_req_if;
  import evpd_pkg::*;
  logic [`EVPD_NUM_MASK-1:0] mreq;
  logic [`EVPD_IDX_W-1:0]    promo_idx;
  logic                      promo_en;
  logic                      hit;
  logic [`EVPD_IDX_W-1:0]    top_idx;
  modport enc (input mreq, input promo_idx, input promo_en, output hit, output top_idx);
  modport top (output mreq, output promo_idx, output promo_en, input hit, input top_idx);
endinterface

/* File: design/evpd_prio_enc.sv */
// maskable source priority encoder with promotion override
`timescale 1ns/1ps
`include "evpd_params.svh"
module evpd_prio_enc
  import evpd_pkg::*;
(
  evpd_req_if.enc req
);
  logic [`EVPD_NUM_MASK:0]   higher;
  logic [`EVPD_NUM_MASK-1:0] win;
  logic [`EVPD_IDX_W-1:0]    idx;
  logic                      promo_hit;

  assign higher[`EVPD_NUM_MASK] = 1'b0;
  // -----------------------------------------------------------------
  // per-source chain
  // -----------------------------------------------------------------
  // higher vector wins
  genvar k;
  generate
    for (k = 0; k < `EVPD_NUM_MASK; k++) begin : g_src
      assign higher[k] = higher[k+1] | req.mreq[k];
      assign win[k]    = req.mreq[k] & ~higher[k+1];
    end
  endgenerate

  always_comb begin
    idx = '0;
    for (int i = 0; i < `EVPD_NUM_MASK; i++) begin
      if (win[i]) begin
        idx = i[`EVPD_IDX_W-1:0];
      end
    end
  end

  assign promo_hit   = req.promo_en & req.mreq[req.promo_idx];
  assign req.hit     = higher[0];
  assign req.top_idx = promo_hit ? req.promo_idx : idx;
endmodule

/* File: design/evpd_top.sv */
// exception vector priority decoder top
`timescale 1ns/1ps
`include "evpd_params.svh"
module evpd_top
  import evpd_pkg::*;
(
  input  wire logic                        ref_clk_i,
  input  wire logic                        rst_i,
  input  wire logic [2:0]                  reset_req_i,
  input  wire logic                        opcode_trap_i,
  input  wire logic                        software_trap_instruction_i,
  input  wire logic                        debug_vector_req_i,
  input  wire logic                        nonmaskable_request_line_n_i,
  input  wire logic                        maskable_request_line_n_i,
  input  wire logic [`EVPD_NUM_PERIPH-1:0] periph_req_i,
  input  wire logic                        cpu_i_mask_i,
  input  wire logic                        cpu_x_mask_i,
  input  wire logic                        special_mode_i,
  input  wire logic [7:0]                  promoted_priority_select_i,
  input  wire logic                        promoted_priority_wr_i,
  input  wire logic                        test_inject_enable_i,
  input  wire logic                        test_inject_enable_wr_i,
  input  wire logic [`EVPD_NUM_INJ-1:0]    injected_request_bits_i,
  input  wire logic                        injected_request_wr_i,
  input  wire logic                        vec_req_i,
  output logic [15:0]                      vec_o,
  output logic                             vec_valid_o,
  output logic                             wakeup_o
);
  evpd_state_t               q;
  evpd_state_t               d;
  evpd_req_if                rq ();
  logic                      inject_act;
  logic                      nonmaskable_request_line_act;
  logic                      nonmaskable_request_line_valid;
  logic [`EVPD_NUM_MASK-1:0] mreq_raw;
  logic                      win_valid;
  logic [15:0]               win_vec;
  logic [15:0]               mask_vec;
  logic                      seen_q;

  // -----------------------------------------------------------------
  // request sources
  // -----------------------------------------------------------------
  // injection needs special mode
  assign inject_act = special_mode_i & q.inj_en;
  assign nonmaskable_request_line_act   = inject_act ? q.inj[`EVPD_NONMASKABLE_REQUEST_LINE_IDX] : ~q.nonmaskable_request_line_sync[1];
  assign mreq_raw   = inject_act ? q.inj[`EVPD_NUM_MASK-1:0] : {~q.irq_sync[1], periph_req_i};
  assign nonmaskable_request_line_valid = nonmaskable_request_line_act & ~cpu_x_mask_i;

  assign rq.mreq      = mreq_raw & {`EVPD_NUM_MASK{~cpu_i_mask_i}};
  // out of range select disables promotion
  assign rq.promo_en  = (q.psel <= `EVPD_PSEL_LIMIT);
  assign rq.promo_idx = q.psel[7:1];

  evpd_prio_enc u_enc (
    .req (rq.enc)
  );

  assign mask_vec = {`EVPD_VEC_PAGE, rq.top_idx, 1'b0};

  // -----------------------------------------------------------------
  // exception priority
  // -----------------------------------------------------------------
  always_comb begin
    win_valid = 1'b1;
    win_vec   = `EVPD_VEC_SWI;
    if (reset_req_i[`EVPD_RST_SYS]) begin
      win_vec = `EVPD_VEC_SYSRST;
    end else if (reset_req_i[`EVPD_RST_CLKMON]) begin
      win_vec = `EVPD_VEC_CLKMON;
    end else if (reset_req_i[`EVPD_RST_WDOG]) begin
      win_vec = `EVPD_VEC_WDOG;
    end else if (opcode_trap_i) begin
      win_vec = `EVPD_VEC_TRAP;
    end else if (software_trap_instruction_i | debug_vector_req_i) begin
      win_vec = `EVPD_VEC_SWI;
    end else if (nonmaskable_request_line_valid) begin
      win_vec = `EVPD_VEC_NONMASKABLE_REQUEST_LINE;
    end else if (rq.hit) begin
      win_vec = mask_vec;
    end else begin
      win_valid = 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // wake path
  // -----------------------------------------------------------------
  // combinational, works with clock stopped
  assign wakeup_o = ~nonmaskable_request_line_n_i
                  | ((~maskable_request_line_n_i | (|periph_req_i)) & ~cpu_i_mask_i);

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  always_comb begin
    d           = q;
    d.nonmaskable_request_line_sync = {q.nonmaskable_request_line_sync[0], nonmaskable_request_line_n_i};
    d.irq_sync  = {q.irq_sync[0], maskable_request_line_n_i};
    if (promoted_priority_wr_i && cpu_i_mask_i) begin
      d.psel = promoted_priority_select_i;
    end
    if (test_inject_enable_wr_i && special_mode_i && cpu_i_mask_i && cpu_x_mask_i) begin
      d.inj_en = test_inject_enable_i;
    end
    // pending injected bits stay until overwritten
    if (injected_request_wr_i && inject_act && cpu_i_mask_i) begin
      d.inj = injected_request_bits_i;
    end
    if (win_valid) begin
      d.last_vec = win_vec;
    end
    d.vec_valid = vec_req_i;
    if (vec_req_i) begin
      // last vector starts at software trap
      d.vec = win_valid ? win_vec : q.last_vec;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      q.nonmaskable_request_line_sync <= 2'h3;
      q.irq_sync  <= 2'h3;
      q.psel      <= `EVPD_PSEL_RST;
      q.inj_en    <= 1'b0;
      q.inj       <= '0;
      q.last_vec  <= `EVPD_VEC_SWI;
      q.vec       <= `EVPD_VEC_SWI;
      q.vec_valid <= 1'b0;
    end else begin
      q <= d;
    end
  end

  assign vec_o       = q.vec;
  assign vec_valid_o = q.vec_valid;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  // helper: any request seen since reset
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      seen_q <= 1'b0;
    end else if (win_valid) begin
      seen_q <= 1'b1;
    end
  end

  sequence s_req;
    vec_req_i && (reset_req_i == 3'h0);
  endsequence

  sequence s_req_mask_only;
    s_req ##0 !opcode_trap_i && !software_trap_instruction_i && !debug_vector_req_i && !nonmaskable_request_line_valid;
  endsequence

  property p_answer_next;
    @(posedge ref_clk_i) disable iff (rst_i)
    vec_req_i |=> vec_valid_o ##1 (vec_valid_o == $past(vec_req_i));
  endproperty
  a_answer_next: assert property (p_answer_next) else $error("vector answer not one cycle after request");

  property p_sysrst;
    @(posedge ref_clk_i) disable iff (rst_i)
    vec_req_i && reset_req_i[`EVPD_RST_SYS] |=> vec_o == `EVPD_VEC_SYSRST;
  endproperty
  a_sysrst: assert property (p_sysrst) else $error("system reset vector wrong");

  property p_clkmon;
    @(posedge ref_clk_i) disable iff (rst_i)
    vec_req_i && (reset_req_i == 3'h2) |=> vec_o == `EVPD_VEC_CLKMON;
  endproperty
  a_clkmon: assert property (p_clkmon) else $error("clock monitor reset vector wrong");

  property p_trap;
    @(posedge ref_clk_i) disable iff (rst_i)
    s_req ##0 opcode_trap_i |=> vec_o == `EVPD_VEC_TRAP;
  endproperty
  a_trap: assert property (p_trap) else $error("opcode trap vector wrong");

  property p_choose_at_req;
    @(posedge ref_clk_i) disable iff (rst_i)
    vec_req_i && win_valid |=> vec_o == $past(win_vec);
  endproperty
  a_choose_at_req: assert property (p_choose_at_req) else $error("vector not taken at request");

  property p_last_valid;
    @(posedge ref_clk_i) disable iff (rst_i)
    vec_req_i && !win_valid && seen_q |=> vec_o == $past(q.last_vec);
  endproperty
  a_last_valid: assert property (p_last_valid) else $error("last valid vector not returned");

  property p_never_pending;
    @(posedge ref_clk_i) disable iff (rst_i)
    vec_req_i && !win_valid && !seen_q |=> vec_o == `EVPD_VEC_SWI;
  endproperty
  a_never_pending: assert property (p_never_pending) else $error("default vector not software trap");

  property p_promoted;
    @(posedge ref_clk_i) disable iff (rst_i)
    s_req_mask_only ##0 rq.promo_en && rq.mreq[q.psel[7:1]]
      |=> vec_o == {`EVPD_VEC_PAGE, $past(q.psel[7:1]), 1'b0};
  endproperty
  a_promoted: assert property (p_promoted) else $error("promoted source not served first");

  property p_irq_top;
    @(posedge ref_clk_i) disable iff (rst_i)
    s_req_mask_only ##0 rq.mreq[`EVPD_IRQ_IDX] && !(rq.promo_en && rq.mreq[q.psel[7:1]])
      |=> vec_o == `EVPD_VEC_IRQ;
  endproperty
  a_irq_top: assert property (p_irq_top) else $error("maskable line not top maskable");

  property p_psel_limit;
    @(posedge ref_clk_i) disable iff (rst_i)
    (q.psel > `EVPD_PSEL_LIMIT) |-> !rq.promo_en;
  endproperty
  a_psel_limit: assert property (p_psel_limit) else $error("promotion above limit active");

  property p_inject_only;
    @(posedge ref_clk_i) disable iff (rst_i)
    inject_act |-> mreq_raw == q.inj[`EVPD_NUM_MASK-1:0];
  endproperty
  a_inject_only: assert property (p_inject_only) else $error("real inputs reach decoder under injection");

  property p_inject_mode;
    @(posedge ref_clk_i) disable iff (rst_i)
    !special_mode_i |-> !inject_act;
  endproperty
  a_inject_mode: assert property (p_inject_mode) else $error("injection active outside special mode");

  property p_wake;
    @(posedge ref_clk_i) disable iff (rst_i)
    !nonmaskable_request_line_n_i |-> wakeup_o;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on nonmaskable request");

  property p_wake_mask;
    @(posedge ref_clk_i) disable iff (rst_i)
    !maskable_request_line_n_i && !cpu_i_mask_i |-> wakeup_o;
  endproperty
  a_wake_mask: assert property (p_wake_mask) else $error("no wake on unmasked maskable line");

  property p_wdog;
    @(posedge ref_clk_i) disable iff (rst_i)
    vec_req_i && (reset_req_i == 3'h4) |=> vec_o == `EVPD_VEC_WDOG;
  endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog reset vector wrong");

  property p_swi;
    @(posedge ref_clk_i) disable iff (rst_i)
    s_req ##0 !opcode_trap_i && (software_trap_instruction_i || debug_vector_req_i)
      |=> vec_o == `EVPD_VEC_SWI;
  endproperty
  a_swi: assert property (p_swi) else $error("software trap vector wrong");

  property p_nonmaskable_request_line;
    @(posedge ref_clk_i) disable iff (rst_i)
    s_req ##0 !opcode_trap_i && !software_trap_instruction_i && !debug_vector_req_i
      && !inject_act && !q.nonmaskable_request_line_sync[1] && !cpu_x_mask_i |=> vec_o == `EVPD_VEC_NONMASKABLE_REQUEST_LINE;
  endproperty
  a_nonmaskable_request_line: assert property (p_nonmaskable_request_line) else $error("nonmaskable line vector wrong");

  property p_mask_order;
    @(posedge ref_clk_i) disable iff (rst_i)
    rq.hit && !(rq.promo_en && rq.mreq[q.psel[7:1]])
      |-> rq.mreq[rq.top_idx] && (((rq.mreq >> rq.top_idx) >> 1) == '0);
  endproperty
  a_mask_order: assert property (p_mask_order) else $error("maskable winner not highest pending");

  property p_inj_wr_gate;
    @(posedge ref_clk_i) disable iff (rst_i)
    injected_request_wr_i && !inject_act |=> q.inj == $past(q.inj);
  endproperty
  a_inj_wr_gate: assert property (p_inj_wr_gate) else $error("injected bits written while inactive");

  property p_inj_en_gate;
    @(posedge ref_clk_i) disable iff (rst_i)
    test_inject_enable_wr_i && !special_mode_i |=> q.inj_en == $past(q.inj_en);
  endproperty
  a_inj_en_gate: assert property (p_inj_en_gate) else $error("injection enable written outside special mode");
endmodule

/* File: tb/evpd_core_model.sv */
// core-side model that fetches exception vectors
`timescale 1ns/1ps
module evpd_core_model (
  input  wire logic        clk_i,
  output logic             vec_req_o,
  input  wire logic [15:0] vec_i,
  input  wire logic        vec_valid_i
);
  initial vec_req_o = 1'b0;
  // ---------------------------------------------
  // vector fetch
  // ---------------------------------------------
  // strobe one cycle, answer next cycle
  task automatic fetch(output logic [15:0] v, output logic ok);
    @(negedge clk_i);
    vec_req_o = 1'b1;
    @(negedge clk_i);
    vec_req_o = 1'b0;
    v = vec_i;
    ok = (vec_valid_i === 1'b1);
    @(negedge clk_i);
    // valid must be a single-cycle pulse
    ok = ok & (vec_valid_i === 1'b0);
  endtask
endmodule

/* File: tb/evpd_top_tb.sv */
// self-checking bench for the exception vector decoder
`timescale 1ns/1ps
module evpd_top_tb;
  logic         clk, rst, trap, software_trap_instruction, dbg, xn, irqn, imask, xmask, spec;
  logic         pwr, ien, ienwr, injwr, vreq, vvalid, wake;
  logic [2:0]   rreq;
  logic [120:0] per;
  logic [7:0]   psel;
  logic [122:0] inj;
  logic [15:0]  vec;
  int           err_total, n_compared;

  evpd_top dut_u (.ref_clk_i(clk), .rst_i(rst), .reset_req_i(rreq), .opcode_trap_i(trap),
    .software_trap_instruction_i(software_trap_instruction), .debug_vector_req_i(dbg), .nonmaskable_request_line_n_i(xn),
    .maskable_request_line_n_i(irqn), .periph_req_i(per), .cpu_i_mask_i(imask), .cpu_x_mask_i(xmask),
    .special_mode_i(spec), .promoted_priority_select_i(psel), .promoted_priority_wr_i(pwr),
    .test_inject_enable_i(ien), .test_inject_enable_wr_i(ienwr), .injected_request_bits_i(inj),
    .injected_request_wr_i(injwr), .vec_req_i(vreq), .vec_o(vec), .vec_valid_o(vvalid), .wakeup_o(wake));
  evpd_core_model core_u (.clk_i(clk), .vec_req_o(vreq), .vec_i(vec), .vec_valid_i(vvalid));

  // ---------------------------------------------
  // helpers
  // ---------------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic ask(input logic [15:0] e);
    logic [15:0] v;
    logic        ok;
    core_u.fetch(v, ok);
    chk(v, e);
    chk({15'h0, ok}, 16'h0001);
  endtask

  // pins pass two sync flops, so allow three edges
  task automatic clr();
    @(negedge clk);
    {rreq, trap, software_trap_instruction, dbg, per, imask, xmask, pwr, ienwr, injwr} = '0;
    {xn, irqn} = 2'b11;
    repeat (3) @(negedge clk);
  endtask

  task automatic wr_psel(input logic [7:0] s);
    @(negedge clk);
    imask = 1'b1;
    psel = s;
    pwr = 1'b1;
    @(negedge clk);
    pwr = 1'b0;
    imask = 1'b0;
  endtask

  // ---------------------------------------------
  // scenarios
  // ---------------------------------------------
  task automatic t_never();
    ask(16'hFFF6);
    $display("never-pending test done");
  endtask

  task automatic t_resets();
    for (int i = 0; i < 3; i++) begin
      clr();
      rreq = 3'(1 << i);
      ask(16'hFFFE - 16'(2 * i));
    end
    rreq = 3'b110;
    ask(16'hFFFC);
    rreq = 3'b111;
    ask(16'hFFFE);
    $display("reset test done");
  endtask

  task automatic t_order();
    clr();
    {trap, software_trap_instruction, xn, irqn, per[120]} = 5'b11001;
    repeat (3) @(negedge clk);
    ask(16'hFFF8);
    trap = 1'b0;
    ask(16'hFFF6);
    software_trap_instruction = 1'b0;
    dbg = 1'b1;
    ask(16'hFFF6);
    dbg = 1'b0;
    ask(16'hFFF4);
    // x mask hides the nonmaskable line from vectoring
    xmask = 1'b1;
    ask(16'hFFF2);
    xmask = 1'b0;
    xn = 1'b1;
    repeat (3) @(negedge clk);
    ask(16'hFFF2);
    irqn = 1'b1;
    repeat (3) @(negedge clk);
    ask(16'hFFF0);
    per = '0;
    {per[5], per[0]} = 2'b11;
    ask(16'hFF0A);
    // later higher request displaces the pending one
    rreq = 3'b100;
    ask(16'hFFFA);
    $display("priority test done");
  endtask

  task automatic t_promo();
    clr();
    wr_psel(8'h10);
    {per[8], per[100], irqn} = 3'b110;
    repeat (3) @(negedge clk);
    ask(16'hFF10);
    wr_psel(8'hF4);
    ask(16'hFFF2);
    wr_psel(8'hF2);
    $display("promotion test done");
  endtask

  task automatic t_last();
    clr();
    per[3] = 1'b1;
    @(negedge clk);
    per[3] = 1'b0;
    ask(16'hFF06);
    $display("last-vector test done");
  endtask

  task automatic t_inject();
    clr();
    // enable write outside special mode is ignored
    {imask, xmask, ien, ienwr} = 4'b1111;
    @(negedge clk);
    {imask, xmask, ienwr} = 3'b000;
    // special mode alone must not start injection
    spec = 1'b1;
    per[120] = 1'b1;
    ask(16'hFFF0);
    {spec, imask, xmask, ienwr} = 4'b1111;
    @(negedge clk);
    ienwr = 1'b0;
    inj = '0;
    inj[50] = 1'b1;
    injwr = 1'b1;
    @(negedge clk);
    {injwr, imask, xmask} = 3'b000;
    ask(16'hFF64);
    spec = 1'b0;
    ask(16'hFFF0);
    $display("injection test done");
  endtask

  task automatic t_wake();
    clr();
    imask = 1'b1;
    per[5] = 1'b1;
    #1 chk({15'h0, wake}, 16'h0000);
    @(negedge clk);
    xn = 1'b0;
    #1 chk({15'h0, wake}, 16'h0001);
    @(negedge clk);
    xn = 1'b1;
    imask = 1'b0;
    #1 chk({15'h0, wake}, 16'h0001);
    @(negedge clk);
    {per[5], irqn} = 2'b00;
    #1 chk({15'h0, wake}, 16'h0001);
    $display("wake test done");
  endtask

  // ---------------------------------------------
  // run control
  // ---------------------------------------------
  task automatic summarize();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // whole run needs well under a thousand cycles
  initial begin
    #200000;
    err_total++;
    summarize();
  end

  initial begin
    err_total = 0;
    n_compared = 0;
    rst = 1'b1;
    {rreq, trap, software_trap_instruction, dbg, per, imask, xmask, spec, psel, pwr, ien, ienwr, inj, injwr} = '0;
    // active-low request lines start released
    {xn, irqn} = 2'b11;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    t_never();
    t_resets();
    t_order();
    t_promo();
    t_last();
    t_inject();
    t_wake();
    summarize();
  end
endmodule
